/* File: rtl/sar_adc_pkg.sv */
// shared constants for the successive-approximation converter control
package sar_adc_pkg;

    ////////////////////////////////////////////////////////////////////////////////////
    localparam int              ADDR_W           = 20;
    localparam logic [19:0]     PER_GATE_ADDR    = 20'hF00F0;
    localparam logic [19:0]     MODE0_ADDR       = 20'hFFF30;
    localparam logic [19:0]     MODE2_ADDR       = 20'hFFF34;
    localparam logic [19:0]     RESULT_WORD_ADDR = 20'hFFF20;
    localparam logic [19:0]     RESULT_BYTE_ADDR = 20'hFFF24;
    localparam logic [7:0]      REG_RESET        = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////////
    // peripheral clock gate: only bits 7, 5, 2, 0 are stored
    localparam int              GATE_ADC_BIT     = 5;
    localparam logic [7:0]      GATE_KEEP        = 8'hA5;

    // mode register 0 layout
    localparam int              RUN_BIT          = 7;
    localparam int              FIXED0_BIT       = 6;
    localparam int              FR_HI            = 5;
    localparam int              FR_LO            = 3;
    localparam int              LV_LO            = 1;
    localparam int              CMP_EN_BIT       = 0;
    localparam logic [7:0]      MODE0_WMASK      = 8'hBF;

    // mode register 2 layout
    localparam int              POSREF_HI        = 7;
    localparam int              POSREF_LO        = 6;
    localparam int              NEGREF_BIT       = 5;
    localparam int              SETTLED_BIT      = 4;
    localparam int              ONESHOT_BIT      = 1;
    localparam int              RES_BIT          = 0;
    localparam logic [7:0]      MODE2_WMASK      = 8'hE3;

    ////////////////////////////////////////////////////////////////////////////////////
    localparam int              CLK_PERIOD_NS    = 25;
    localparam int              STAB_TIME_NS     = 1000;
    localparam logic [5:0]      STAB_CYCLES      =
        6'((STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [2:0]      SAMPLE_LONG      = 3'h7;
    localparam logic [2:0]      SAMPLE_SHORT     = 3'h5;
    localparam logic [3:0]      MSB_IDX          = 4'h9;
    localparam logic [3:0]      LSB_IDX_10       = 4'h0;
    localparam logic [3:0]      LSB_IDX_8        = 4'h2;
    localparam logic [9:0]      SAR_MSB_TRIAL    = 10'h200;

    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_COMPARE, ST_LOAD} conv_state_t;

    // conversion clock divide ratio minus one, per clock select code
    function automatic logic [5:0] div_from_fr(input logic [2:0] fr);
        case (fr)
            3'h0:    div_from_fr = 6'h3F;
            3'h1:    div_from_fr = 6'h1F;
            3'h2:    div_from_fr = 6'h0F;
            3'h3:    div_from_fr = 6'h07;
            3'h4:    div_from_fr = 6'h05;
            3'h5:    div_from_fr = 6'h04;
            3'h6:    div_from_fr = 6'h03;
            default: div_from_fr = 6'h01;
        endcase
    endfunction

endpackage

/* File: rtl/sar_adc_control.sv */
// converter control: register slave, approximation sequencer, result registers
//
// The implementer's own choice: the Wishbone register port.
module sar_adc_control (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [19:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        comp_greater,
    input  wire logic        limit_in_range,
    output logic             sample_hold,
    output logic      [9:0]  trial_code,
    output logic      [1:0]  pos_ref_sel,
    output logic             neg_ref_sel,
    output logic             comparator_enable,
    output logic             converter_reset_n,
    output logic             conversion_done_irq
);

    ////////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic                      ack;
        logic [31:0]               rdat;
        logic [7:0]                gate;
        logic [7:0]                mode0;
        logic [7:0]                mode2;
        logic [9:0]                result;
        logic [5:0]                div_cnt;
        logic                      fad_en;
        sar_adc_pkg::conv_state_t  state;
        logic [2:0]                samp_cnt;
        logic [3:0]                bit_idx;
        logic [9:0]                sar;
        logic                      hold;
        logic                      irq_stage;
        logic                      irq;
        logic [5:0]                stab_cnt;
        logic                      settled;
    } ctrl_state_t;

    ctrl_state_t st_ff;
    ctrl_state_t nxt_st;

    logic        req;
    logic        wr_lo;
    logic        gate_on;
    logic        running;
    logic [3:0]  last_idx;
    logic [3:0]  lower_idx;
    logic [2:0]  samp_load;

    ////////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st    = st_ff;
        req       = wb_cyc_i && wb_stb_i && !st_ff.ack;
        wr_lo     = req && wb_we_i && wb_sel_i[0];
        gate_on   = st_ff.gate[sar_adc_pkg::GATE_ADC_BIT];
        running   = st_ff.mode0[sar_adc_pkg::RUN_BIT] && st_ff.mode0[sar_adc_pkg::CMP_EN_BIT];
        last_idx  = st_ff.mode2[sar_adc_pkg::RES_BIT] ? sar_adc_pkg::LSB_IDX_8
                                                      : sar_adc_pkg::LSB_IDX_10;
        lower_idx = 4'(st_ff.bit_idx - 4'h1);
        samp_load = st_ff.mode0[sar_adc_pkg::LV_LO] ? 3'(sar_adc_pkg::SAMPLE_SHORT - 3'h1)
                                                    : 3'(sar_adc_pkg::SAMPLE_LONG - 3'h1);

        // one-cycle answer; unmapped reads give zero
        nxt_st.ack  = req;
        nxt_st.rdat = '0;
        nxt_st.irq  = 1'b0;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                sar_adc_pkg::PER_GATE_ADDR:    nxt_st.rdat = {24'h0, st_ff.gate};
                sar_adc_pkg::MODE0_ADDR:       nxt_st.rdat = {24'h0, st_ff.mode0};
                sar_adc_pkg::MODE2_ADDR: begin
                    nxt_st.rdat = {24'h0, st_ff.mode2};
                    nxt_st.rdat[sar_adc_pkg::SETTLED_BIT] = st_ff.settled;
                end
                sar_adc_pkg::RESULT_WORD_ADDR: nxt_st.rdat = {16'h0, st_ff.result, 6'h0};
                sar_adc_pkg::RESULT_BYTE_ADDR: nxt_st.rdat = {24'h0, st_ff.result[9:2]};
                default:                       nxt_st.rdat = '0;
            endcase
        end

        if (!gate_on) begin
            // whole converter held at reset values while its clock is off
            nxt_st.mode0     = sar_adc_pkg::REG_RESET;
            nxt_st.mode2     = sar_adc_pkg::REG_RESET;
            nxt_st.result    = '0;
            nxt_st.div_cnt   = '0;
            nxt_st.fad_en    = 1'b0;
            nxt_st.state     = sar_adc_pkg::ST_IDLE;
            nxt_st.samp_cnt  = '0;
            nxt_st.bit_idx   = '0;
            nxt_st.sar       = '0;
            nxt_st.hold      = 1'b0;
            nxt_st.irq_stage = 1'b0;
            nxt_st.stab_cnt  = '0;
            nxt_st.settled   = 1'b0;
        end else begin
            nxt_st.irq_stage = 1'b0;
            nxt_st.irq       = st_ff.irq_stage && limit_in_range;

            // conversion clock enable from the selected divide ratio
            if (st_ff.div_cnt == 6'h00) begin
                nxt_st.div_cnt = sar_adc_pkg::div_from_fr(
                    st_ff.mode0[sar_adc_pkg::FR_HI:sar_adc_pkg::FR_LO]);
                nxt_st.fad_en  = 1'b1;
            end else begin
                nxt_st.div_cnt = 6'(st_ff.div_cnt - 6'h01);
                nxt_st.fad_en  = 1'b0;
            end

            // settling flag only informs software; start is not blocked by it
            if (!st_ff.mode0[sar_adc_pkg::CMP_EN_BIT]) begin
                nxt_st.stab_cnt = '0;
                nxt_st.settled  = 1'b0;
            end else if (st_ff.stab_cnt != sar_adc_pkg::STAB_CYCLES) begin
                nxt_st.stab_cnt = 6'(st_ff.stab_cnt + 6'h01);
            end else begin
                nxt_st.settled  = 1'b1;
            end

            if (!running) begin
                nxt_st.state = sar_adc_pkg::ST_IDLE;
                nxt_st.hold  = 1'b0;
            end else if (st_ff.fad_en) begin
                case (st_ff.state)
                    sar_adc_pkg::ST_IDLE: begin
                        nxt_st.state    = sar_adc_pkg::ST_SAMPLE;
                        nxt_st.samp_cnt = samp_load;
                        nxt_st.hold     = 1'b0;
                    end
                    sar_adc_pkg::ST_SAMPLE: begin
                        if (st_ff.samp_cnt == 3'h0) begin
                            nxt_st.hold    = 1'b1;
                            nxt_st.sar     = sar_adc_pkg::SAR_MSB_TRIAL;
                            nxt_st.bit_idx = sar_adc_pkg::MSB_IDX;
                            nxt_st.state   = sar_adc_pkg::ST_COMPARE;
                        end else begin
                            nxt_st.samp_cnt = 3'(st_ff.samp_cnt - 3'h1);
                        end
                    end
                    sar_adc_pkg::ST_COMPARE: begin
                        nxt_st.sar[st_ff.bit_idx] = comp_greater;
                        // at or below the last bit also ends, so a resolution change cannot run on
                        if (st_ff.bit_idx <= last_idx) begin
                            nxt_st.state = sar_adc_pkg::ST_LOAD;
                        end else begin
                            nxt_st.bit_idx        = lower_idx;
                            nxt_st.sar[lower_idx] = 1'b1;
                        end
                    end
                    sar_adc_pkg::ST_LOAD: begin
                        nxt_st.result    = st_ff.sar;
                        nxt_st.irq_stage = 1'b1;
                        nxt_st.hold      = 1'b0;
                        if (st_ff.mode2[sar_adc_pkg::ONESHOT_BIT]) begin
                            nxt_st.mode0[sar_adc_pkg::RUN_BIT] = 1'b0;
                            nxt_st.state = sar_adc_pkg::ST_IDLE;
                        end else begin
                            nxt_st.state    = sar_adc_pkg::ST_SAMPLE;
                            nxt_st.samp_cnt = samp_load;
                        end
                    end
                    default: nxt_st.state = sar_adc_pkg::ST_IDLE;
                endcase
            end

            // software write lands after the hardware clear, so a set wins
            if (wr_lo && wb_adr_i == sar_adc_pkg::MODE0_ADDR) begin
                nxt_st.mode0 = wb_dat_i[7:0] & sar_adc_pkg::MODE0_WMASK;
            end
            if (wr_lo && wb_adr_i == sar_adc_pkg::MODE2_ADDR) begin
                nxt_st.mode2 = (st_ff.mode2 & ~sar_adc_pkg::MODE2_WMASK)
                             | (wb_dat_i[7:0] & sar_adc_pkg::MODE2_WMASK);
            end
        end

        // result registers have no write path; the gate is always writable
        if (wr_lo && wb_adr_i == sar_adc_pkg::PER_GATE_ADDR) begin
            nxt_st.gate = wb_dat_i[7:0] & sar_adc_pkg::GATE_KEEP;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    assign wb_dat_o            = st_ff.rdat;
    assign wb_ack_o            = st_ff.ack;
    assign sample_hold         = st_ff.hold;
    assign trial_code          = st_ff.sar;
    assign pos_ref_sel         = st_ff.mode2[sar_adc_pkg::POSREF_HI:sar_adc_pkg::POSREF_LO];
    assign neg_ref_sel         = st_ff.mode2[sar_adc_pkg::NEGREF_BIT];
    assign comparator_enable   = st_ff.mode0[sar_adc_pkg::CMP_EN_BIT];
    assign converter_reset_n   = st_ff.gate[sar_adc_pkg::GATE_ADC_BIT];
    assign conversion_done_irq = st_ff.irq;

    ////////////////////////////////////////////////////////////////////////////////////
    ack_single_a: assert property (@(posedge ref_clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    gate_off_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
        !st_ff.gate[sar_adc_pkg::GATE_ADC_BIT] |=> (st_ff.mode0 == 8'h00)
            && (st_ff.result == 10'h000) && !sample_hold)
        else $error("converter not held in reset while gate off");

    msb_trial_a: assert property (@(posedge ref_clk) disable iff (rst)
        (st_ff.state == sar_adc_pkg::ST_SAMPLE && nxt_st.state == sar_adc_pkg::ST_COMPARE)
            |=> (trial_code == 10'h200) && (st_ff.bit_idx == 4'h9) && sample_hold)
        else $error("first trial is not half reference");

    second_tap_a: assert property (@(posedge ref_clk) disable iff (rst)
        (st_ff.state == sar_adc_pkg::ST_COMPARE && st_ff.fad_en && running
            && st_ff.bit_idx == 4'h9 && gate_on)
            |=> (trial_code[9] == $past(comp_greater)) && trial_code[8]
                && (trial_code[7:0] == 8'h00))
        else $error("bit 8 trial tap wrong");

    stop_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
        (st_ff.state == sar_adc_pkg::ST_COMPARE && st_ff.mode2[sar_adc_pkg::RES_BIT])
            |-> (st_ff.bit_idx >= 4'h2) && (trial_code[1:0] == 2'b00))
        else $error("8-bit conversion went below bit 2");

    result_load_a: assert property (@(posedge ref_clk) disable iff (rst)
        (st_ff.state == sar_adc_pkg::ST_LOAD && st_ff.fad_en && running && gate_on)
            |=> (st_ff.result == $past(st_ff.sar)) ##1 (st_ff.state != sar_adc_pkg::ST_LOAD))
        else $error("result not loaded from approximation");

    irq_path_a: assert property (@(posedge ref_clk) disable iff (rst)
        conversion_done_irq |-> $past(st_ff.irq_stage) && $past(limit_in_range))
        else $error("end request without completed conversion");

    word_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        (req && !wb_we_i && wb_adr_i == sar_adc_pkg::RESULT_WORD_ADDR)
            |=> wb_ack_o && (wb_dat_o[5:0] == 6'h00) && (wb_dat_o[15:6] == $past(st_ff.result)))
        else $error("word result not left-justified");

    oneshot_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        (st_ff.state == sar_adc_pkg::ST_LOAD && st_ff.fad_en && running && gate_on
            && st_ff.mode2[sar_adc_pkg::ONESHOT_BIT]
            && !(wr_lo && wb_adr_i == sar_adc_pkg::MODE0_ADDR))
            |=> !st_ff.mode0[sar_adc_pkg::RUN_BIT])
        else $error("one-shot run bit not cleared");

    hold_steady_a: assert property (@(posedge ref_clk) disable iff (rst)
        (st_ff.state == sar_adc_pkg::ST_COMPARE) |-> sample_hold)
        else $error("input released during approximation");

    fixed_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
        !st_ff.mode0[sar_adc_pkg::FIXED0_BIT])
        else $error("mode register bit 6 not zero");

    byte_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        (req && !wb_we_i && wb_adr_i == sar_adc_pkg::RESULT_BYTE_ADDR)
            |=> wb_ack_o && (wb_dat_o[31:8] == 24'h000000)
                && (wb_dat_o[7:0] == $past(st_ff.result[9:2])))
        else $error("byte result not upper eight bits");

    run_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
        !running |=> !sample_hold && (st_ff.state == sar_adc_pkg::ST_IDLE))
        else $error("conversion kept going with run bit clear");

    gate_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_lo && wb_adr_i == sar_adc_pkg::PER_GATE_ADDR)
            |=> (converter_reset_n == $past(wb_dat_i[sar_adc_pkg::GATE_ADC_BIT])))
        else $error("converter reset does not follow gate bit");

    gate_off_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_lo && !gate_on && (wb_adr_i == sar_adc_pkg::MODE0_ADDR
            || wb_adr_i == sar_adc_pkg::MODE2_ADDR))
            |=> (st_ff.mode0 == 8'h00) && (st_ff.mode2 == 8'h00))
        else $error("mode write landed while gate off");

    mode0_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_lo && gate_on && wb_adr_i == sar_adc_pkg::MODE0_ADDR)
            |=> (st_ff.mode0 == ($past(wb_dat_i[7:0]) & sar_adc_pkg::MODE0_WMASK)))
        else $error("mode register 0 write lost");

    cmp_enable_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_lo && gate_on && wb_adr_i == sar_adc_pkg::MODE0_ADDR)
            |=> (comparator_enable == $past(wb_dat_i[sar_adc_pkg::CMP_EN_BIT])))
        else $error("comparator enable not following its bit");

    ref_route_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_lo && gate_on && wb_adr_i == sar_adc_pkg::MODE2_ADDR)
            |=> (pos_ref_sel == $past(wb_dat_i[sar_adc_pkg::POSREF_HI:sar_adc_pkg::POSREF_LO]))
                && (neg_ref_sel == $past(wb_dat_i[sar_adc_pkg::NEGREF_BIT])))
        else $error("reference select not routed");

    step_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        (st_ff.state == sar_adc_pkg::ST_COMPARE && !st_ff.fad_en && gate_on)
            |=> $stable(trial_code))
        else $error("trial code moved between conversion clock steps");

    irq_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
        conversion_done_irq |=> !conversion_done_irq)
        else $error("end request longer than one cycle");

    res_eight_a: assert property (@(posedge ref_clk) disable iff (rst)
        (st_ff.state == sar_adc_pkg::ST_LOAD && st_ff.fad_en && running && gate_on
            && st_ff.mode2[sar_adc_pkg::RES_BIT])
            |=> (st_ff.result[1:0] == 2'h0))
        else $error("8-bit result has low bits set");

    result_ro_a: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_lo && gate_on && st_ff.state != sar_adc_pkg::ST_LOAD
            && (wb_adr_i == sar_adc_pkg::RESULT_WORD_ADDR
                || wb_adr_i == sar_adc_pkg::RESULT_BYTE_ADDR))
            |=> $stable(st_ff.result))
        else $error("result register changed by a write");

endmodule

/* File: tb/testbench.sv */
// self-checking bench for the converter control block
`define check(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////////////////////////////
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [19:0] wb_adr_i = 20'h00000;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        comp_greater = 1'b0;
    logic        limit_in_range = 1'b1;
    logic        sample_hold;
    logic [9:0]  trial_code;
    logic [1:0]  pos_ref_sel;
    logic        neg_ref_sel;
    logic        comparator_enable;
    logic        converter_reset_n;
    logic        conversion_done_irq;
    logic [9:0]  target_code = 10'h000;
    int          num_errors = 0;
    int          samples_checked = 0;

    sar_adc_control uut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .comp_greater(comp_greater), .limit_in_range(limit_in_range),
        .sample_hold(sample_hold), .trial_code(trial_code), .pos_ref_sel(pos_ref_sel),
        .neg_ref_sel(neg_ref_sel), .comparator_enable(comparator_enable),
        .converter_reset_n(converter_reset_n), .conversion_done_irq(conversion_done_irq));

    always #12.5 ref_clk = ~ref_clk;

    // held input seen by the comparator; one cycle lag is harmless at eight cycles a step
    always @(posedge ref_clk) comp_greater <= (target_code >= trial_code);

    ////////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wb_xfer(input logic we, input logic [19:0] a, input logic [7:0] d,
                           output logic [31:0] q);
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h000000, d};
        do begin
            @(posedge ref_clk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb_xfer(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [19:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb_xfer(1'b0, a, 8'h00, q);
        `check(q, e)
    endtask

    ////////////////////////////////////////////////////////////////////////////////////
    task automatic test_gate();
        wr(sar_adc_pkg::MODE0_ADDR, 8'h01);
        rd_chk(sar_adc_pkg::MODE0_ADDR, 32'h00000000);
        `check(comparator_enable, 1'b0)
        `check(converter_reset_n, 1'b0)
        wr(sar_adc_pkg::PER_GATE_ADDR, 8'hFF);
        rd_chk(sar_adc_pkg::PER_GATE_ADDR, 32'h000000A5);
        `check(converter_reset_n, 1'b1)
        wr(sar_adc_pkg::PER_GATE_ADDR, 8'h20);
        $display("test gate done");
    endtask

    task automatic test_mode0();
        wr(sar_adc_pkg::MODE0_ADDR, 8'h7E);
        rd_chk(sar_adc_pkg::MODE0_ADDR, 32'h0000003E);
        `check(comparator_enable, 1'b0)
        wr(sar_adc_pkg::MODE0_ADDR, 8'h01);
        `check(comparator_enable, 1'b1)
        wr(sar_adc_pkg::MODE2_ADDR, 8'h60);
        `check(pos_ref_sel, 2'b01)
        `check(neg_ref_sel, 1'b1)
        $display("test mode done");
    endtask

    // one-shot conversion at eight cycles a step, five sample steps
    task automatic run_conv(input logic [7:0] m2, input logic [9:0] tgt, input logic lim,
                            input logic [31:0] ew, input logic [31:0] eb);
        logic [31:0] q;
        int n;
        int pulses;
        target_code    <= tgt;
        limit_in_range <= lim;
        wr(sar_adc_pkg::MODE2_ADDR, m2);
        wr(sar_adc_pkg::MODE0_ADDR, 8'h1B);
        repeat (40) @(posedge ref_clk);
        wr(sar_adc_pkg::MODE0_ADDR, 8'h9B);
        wb_xfer(1'b0, sar_adc_pkg::MODE0_ADDR, 8'h00, q);
        `check(q[7], 1'b1)
        n = 0;
        do begin @(posedge ref_clk); n++; end while (sample_hold !== 1'b1);
        `check(trial_code, 10'h200)
        @(posedge ref_clk);
        n = 0;
        do begin @(posedge ref_clk); n++; end while (sample_hold !== 1'b0);
        `check(n, m2[sar_adc_pkg::RES_BIT] ? 71 : 87)
        pulses = 0;
        repeat (4) begin @(posedge ref_clk); if (conversion_done_irq === 1'b1) pulses++; end
        `check(pulses, int'(lim))
        rd_chk(sar_adc_pkg::RESULT_WORD_ADDR, ew);
        rd_chk(sar_adc_pkg::RESULT_BYTE_ADDR, eb);
        rd_chk(sar_adc_pkg::MODE0_ADDR, 32'h0000001B);
        $display("test conversion done");
    endtask

    // sequential run, long sampling: no idle step between conversions, then an abort
    task automatic test_seq();
        int n;
        int pulses;
        target_code    <= 10'h155;
        limit_in_range <= 1'b1;
        wr(sar_adc_pkg::MODE2_ADDR, 8'h00);
        wr(sar_adc_pkg::MODE0_ADDR, 8'h19);
        wr(sar_adc_pkg::MODE0_ADDR, 8'h99);
        do begin @(posedge ref_clk); end while (conversion_done_irq !== 1'b1);
        n = 0;
        do begin @(posedge ref_clk); n++; end while (conversion_done_irq !== 1'b1);
        `check(n, 144)
        rd_chk(sar_adc_pkg::MODE0_ADDR, 32'h00000099);
        rd_chk(sar_adc_pkg::RESULT_WORD_ADDR, 32'h00005540);
        do begin @(posedge ref_clk); end while (sample_hold !== 1'b1);
        wr(sar_adc_pkg::MODE0_ADDR, 8'h19);
        @(posedge ref_clk);
        `check(sample_hold, 1'b0)
        pulses = 0;
        repeat (200) begin @(posedge ref_clk); if (conversion_done_irq === 1'b1) pulses++; end
        `check(pulses, 0)
        rd_chk(sar_adc_pkg::MODE2_ADDR, 32'h00000010);
        $display("test sequential done");
    endtask

    task automatic test_readonly();
        wr(sar_adc_pkg::RESULT_WORD_ADDR, 8'h55);
        rd_chk(sar_adc_pkg::RESULT_WORD_ADDR, 32'h0000FF00);
        rd_chk(20'h00000, 32'h00000000);
        wr(sar_adc_pkg::PER_GATE_ADDR, 8'h00);
        rd_chk(sar_adc_pkg::RESULT_BYTE_ADDR, 32'h00000000);
        `check(converter_reset_n, 1'b0)
        `check(comparator_enable, 1'b0)
        $display("test read-only done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        test_gate();
        test_mode0();
        test_seq();
        run_conv(8'h62, 10'h2A5, 1'b1, 32'h0000A940, 32'h000000A9);
        run_conv(8'h03, 10'h3FF, 1'b0, 32'h0000FF00, 32'h000000FF);
        test_readonly();
        end_sim();
    end

    // whole run is well under two thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        end_sim();
    end
endmodule
